// ---- design/bmf_pkg.sv ----
// Constants shared by the block memory and FIFO design
package bmf_pkg;
   // -------------------------------------------------
   // Array geometry
   // -------------------------------------------------
   localparam int unsigned MEM_BITS = 9216;
   localparam int unsigned ADDR_W   = 13;
   localparam int unsigned DATA_W   = 18;
   localparam int unsigned PTR_W    = 14;
   localparam int unsigned OFF_W    = 14;
   localparam int unsigned WID_W    = 5;
   localparam int unsigned INIT_AW  = 10;
   localparam int unsigned INIT_DW  = 9;

   // -------------------------------------------------
   // Width codes (words x bits)
   // -------------------------------------------------
   localparam logic [2:0] WID_X1  = 3'h0;
   localparam logic [2:0] WID_X2  = 3'h1;
   localparam logic [2:0] WID_X4  = 3'h2;
   localparam logic [2:0] WID_X9  = 3'h3;
   localparam logic [2:0] WID_X18 = 3'h4;

   // -------------------------------------------------
   // Memory modes
   // -------------------------------------------------
   localparam logic [2:0] MODE_SINGLE = 3'h0;
   localparam logic [2:0] MODE_DUAL   = 3'h1;
   localparam logic [2:0] MODE_PSEUDO = 3'h2;
   localparam logic [2:0] MODE_FIFO   = 3'h3;
   localparam logic [2:0] MODE_ROM    = 3'h4;

   // -------------------------------------------------
   // Write behaviours
   // -------------------------------------------------
   localparam logic [1:0] WR_NORMAL  = 2'h0;
   localparam logic [1:0] WR_THROUGH = 2'h1;
   localparam logic [1:0] WR_RBW     = 2'h2;

   // -------------------------------------------------
   // Reset values
   // -------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
   localparam logic [PTR_W-1:0]  PTR_RST  = 14'h0000;
endpackage

// ---- design/bmf_block_memory.sv ----
// Nine-kilobit block memory with RAM, ROM and FIFO modes
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module bmf_block_memory
   import bmf_pkg::*;
(
   // Clock, reset, freeze
   input  wire  logic                 clk,
   input  wire  logic                 sys_rst,
   input  wire  logic                 clkEn,
   input  wire  logic                 chipWideResetN,
   // Static configuration
   input  wire  logic [2:0]           memMode,
   input  wire  logic [2:0]           widthA,
   input  wire  logic [2:0]           widthB,
   input  wire  logic [1:0]           writeModeA,
   input  wire  logic [1:0]           writeModeB,
   input  wire  logic                 outRegEnA,
   input  wire  logic                 outRegEnB,
   input  wire  logic                 latchRstSyncA,
   input  wire  logic                 latchRstSyncB,
   // Configuration-time preload
   input  wire  logic                 initLoad,
   input  wire  logic [INIT_AW-1:0]   initAddr,
   input  wire  logic [INIT_DW-1:0]   initWord,
   // RAM port A
   input  wire  logic                 portClkEnA,
   input  wire  logic                 portSelA,
   input  wire  logic                 writeEnA,
   input  wire  logic [ADDR_W-1:0]    addrA,
   input  wire  logic [DATA_W-1:0]    writeWordInA,
   input  wire  logic                 outputClockEnableA,
   input  wire  logic                 portALatchReset,
   output logic [DATA_W-1:0]          readWordA,
   // RAM port B
   input  wire  logic                 portClkEnB,
   input  wire  logic                 portSelB,
   input  wire  logic                 writeEnB,
   input  wire  logic [ADDR_W-1:0]    addrB,
   input  wire  logic [DATA_W-1:0]    writeWordInB,
   input  wire  logic                 outputClockEnableB,
   input  wire  logic                 portBLatchReset,
   output logic [DATA_W-1:0]          readWordB,
   // FIFO write side (data on writeWordInA)
   input  wire  logic                 writeClockGate,
   input  wire  logic                 fifoWriteEn,
   input  wire  logic [1:0]           writePortSelect,
   input  wire  logic                 fullChainInput,
   input  wire  logic [2:0]           writeSelMatch,
   // FIFO read side (data on readWordB)
   input  wire  logic                 readClockGate,
   input  wire  logic                 fetchEnable,
   input  wire  logic                 outputReadEnable,
   input  wire  logic [1:0]           readPortSelect,
   input  wire  logic                 emptyChainInput,
   input  wire  logic [2:0]           readSelMatch,
   // FIFO control and flags
   input  wire  logic                 fifoReset,
   input  wire  logic                 readPointerRewindInput,
   input  wire  logic [PTR_W-1:0]     fullThreshold,
   input  wire  logic [PTR_W-1:0]     nearlyFullThreshold,
   input  wire  logic [PTR_W-1:0]     nearlyEmptyThreshold,
   output logic                       fullFlag,
   output logic                       nearlyFullFlag,
   output logic                       emptyFlag,
   output logic                       nearlyEmptyFlag
);

   // -------------------------------------------------
   // Width and depth helpers
   // -------------------------------------------------
   function automatic logic [WID_W-1:0] widthOf(input logic [2:0] code);
      case (code)
         WID_X1:  widthOf = 5'h01;
         WID_X2:  widthOf = 5'h02;
         WID_X4:  widthOf = 5'h04;
         WID_X9:  widthOf = 5'h09;
         WID_X18: widthOf = 5'h12;
         default: widthOf = 5'h09;
      endcase
   endfunction

   // Depth halves with each width code step, so the mask is a plain shift
   function automatic logic [ADDR_W-1:0] addrMask(input logic [2:0] code);
      addrMask = (code <= WID_X18) ? (13'h1FFF >> code) : 13'h03FF;
   endfunction

   // Word k of width w starts at bit k*w, same rule for every port
   function automatic logic [OFF_W-1:0] bitOffset(input logic [ADDR_W-1:0] addr,
                                                   input logic [2:0]        code);
      bitOffset = OFF_W'((addr & addrMask(code)) * widthOf(code));
   endfunction

   function automatic logic [DATA_W-1:0] fetchWord(input logic [MEM_BITS-1:0] bits,
                                                    input logic [OFF_W-1:0]    off,
                                                    input logic [2:0]          code);
      logic [WID_W-1:0] w;
      w = widthOf(code);
      fetchWord = DATA_RST;
      for (int i = 0; i < DATA_W; i++) begin
         if (i < int'(w) && (int'(off) + i) < MEM_BITS) begin
            fetchWord[i] = bits[int'(off) + i];
         end
      end
   endfunction

   // -------------------------------------------------
   // Mode decode
   // -------------------------------------------------
   logic isFifo;
   logic isRom;
   logic canWriteB;
   logic portBUsed;

   assign isFifo    = (memMode == MODE_FIFO);
   assign isRom     = (memMode == MODE_ROM);
   assign canWriteB = (memMode == MODE_DUAL);
   assign portBUsed = (memMode == MODE_DUAL) || (memMode == MODE_PSEUDO);

   // -------------------------------------------------
   // Storage array
   // -------------------------------------------------
   // No reset on the array: contents survive resets, only preload defines them
   logic [MEM_BITS-1:0] memBits_ff;

   // -------------------------------------------------
   // FIFO pointers and flags
   // -------------------------------------------------
   logic [PTR_W-1:0] wrPtr_ff;
   logic [PTR_W-1:0] rdPtr_ff;
   logic [PTR_W-1:0] fillCount;
   logic             wrGo;
   logic             rdGo;
   logic             fifoClr;
   logic             rdClr;
   logic [2:0]       wrSelEff;
   logic [2:0]       rdSelEff;
   logic [OFF_W-1:0] wrOff;
   logic [OFF_W-1:0] rdOff;

   assign wrSelEff  = {fullChainInput, writePortSelect};
   assign rdSelEff  = {emptyChainInput, readPortSelect};
   assign fillCount = wrPtr_ff - rdPtr_ff;
   // Chip-wide reset is always live in FIFO mode
   assign fifoClr   = sys_rst | fifoReset | ~chipWideResetN;
   assign rdClr     = fifoClr | readPointerRewindInput;

   // The raw count gates strobes so a same-cycle write cannot overrun the array
   assign wrGo = clkEn & isFifo & writeClockGate & fifoWriteEn
                 & (wrSelEff == writeSelMatch) & (fillCount < fullThreshold);
   assign rdGo = clkEn & isFifo & readClockGate & fetchEnable
                 & (rdSelEff == readSelMatch) & (fillCount != PTR_RST);

   // FIFO uses port A's shape on both sides
   assign wrOff = bitOffset(wrPtr_ff[ADDR_W-1:0], widthA);
   assign rdOff = bitOffset(rdPtr_ff[ADDR_W-1:0], widthA);

   always_ff @(posedge clk or posedge fifoClr) begin
      if (fifoClr) begin
         wrPtr_ff <= PTR_RST;
      end else if (wrGo) begin
         wrPtr_ff <= wrPtr_ff + 14'h0001;
      end
   end

   always_ff @(posedge clk or posedge rdClr) begin
      if (rdClr) begin
         rdPtr_ff <= PTR_RST;
      end else if (rdGo) begin
         rdPtr_ff <= rdPtr_ff + 14'h0001;
      end
   end

   // Write-side flags
   always_ff @(posedge clk or posedge fifoClr) begin
      if (fifoClr) begin
         fullFlag       <= 1'b0;
         nearlyFullFlag <= 1'b0;
      end else if (clkEn) begin
         fullFlag       <= (fillCount >= fullThreshold);
         nearlyFullFlag <= (fillCount >= nearlyFullThreshold);
      end
   end

   // Read-side flags; empty threshold is fixed at zero
   always_ff @(posedge clk or posedge fifoClr) begin
      if (fifoClr) begin
         emptyFlag       <= 1'b1;
         nearlyEmptyFlag <= 1'b1;
      end else if (clkEn) begin
         emptyFlag       <= (fillCount == PTR_RST);
         nearlyEmptyFlag <= (fillCount <= nearlyEmptyThreshold);
      end
   end

   // -------------------------------------------------
   // Per-port input capture, latch and output register
   // -------------------------------------------------
   logic [1:0]              pClkEn;
   logic [1:0]              pSel;
   logic [1:0]              pWe;
   logic [1:0]              pOce;
   logic [1:0]              pLatchRst;
   logic [1:0]              pRstSync;
   logic [1:0]              pOutReg;
   logic [1:0]              pWritable;
   logic [1:0]              pEnabled;
   logic [ADDR_W-1:0]       pAddr [2];
   logic [DATA_W-1:0]       pData [2];
   logic [2:0]              pWidth [2];
   logic [1:0]              pWrMode [2];
   logic [DATA_W-1:0]       pRead [2];

   assign pClkEn    = {portClkEnB, portClkEnA};
   assign pSel      = {portSelB, portSelA};
   assign pWe       = {writeEnB, writeEnA};
   assign pOce      = {(isFifo ? outputReadEnable : outputClockEnableB), outputClockEnableA};
   assign pLatchRst = {portBLatchReset, portALatchReset};
   assign pRstSync  = {latchRstSyncB, latchRstSyncA};
   assign pOutReg   = {outRegEnB, outRegEnA};
   assign pWritable = {canWriteB, ~isRom & ~isFifo};
   assign pEnabled  = {portBUsed | isRom, ~isFifo};
   assign pAddr[0]   = addrA;
   assign pAddr[1]   = addrB;
   assign pData[0]   = writeWordInA;
   assign pData[1]   = writeWordInB;
   assign pWidth[0]  = widthA;
   assign pWidth[1]  = widthB;
   assign pWrMode[0] = writeModeA;
   assign pWrMode[1] = writeModeB;
   logic [1:0]              wrReq;
   logic [OFF_W-1:0]        wrOffP [2];
   logic [DATA_W-1:0]       wrDataP [2];

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : gPort
         logic [ADDR_W-1:0] addr_ff;
         logic [DATA_W-1:0] data_ff;
         logic              we_ff;
         logic              go_ff;
         logic [DATA_W-1:0] latch_ff;
         logic [DATA_W-1:0] out_ff;
         logic [OFF_W-1:0]  off;
         logic              latchClr;
         logic              latchLoad;
         logic [DATA_W-1:0] nxt_latch;

         assign off      = bitOffset(addr_ff, pWidth[p]);
         // Async clear is gated by configuration; user must keep enables quiet around it
         assign latchClr = sys_rst | ~chipWideResetN
                           | (pLatchRst[p] & ~pRstSync[p]);

         // Address, data and strobe captured at the array input
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               addr_ff <= '0;
               data_ff <= DATA_RST;
               we_ff   <= 1'b0;
               go_ff   <= 1'b0;
            end else if (clkEn) begin
               go_ff <= pClkEn[p] & pSel[p] & pEnabled[p];
               if (pClkEn[p]) begin
                  addr_ff <= pAddr[p];
                  data_ff <= pData[p];
                  we_ff   <= pWe[p] & pWritable[p];
               end
            end
         end

         always_comb begin
            latchLoad = 1'b0;
            nxt_latch = latch_ff;
            if (p == 1 && rdGo) begin
               latchLoad = 1'b1;
               nxt_latch = fetchWord(memBits_ff, rdOff, widthA);
            end else if (!isFifo && go_ff) begin
               if (!we_ff) begin
                  latchLoad = 1'b1;
                  nxt_latch = fetchWord(memBits_ff, off, pWidth[p]);
               end else begin
                  case (pWrMode[p])
                     WR_NORMAL: begin
                        latchLoad = 1'b0;
                     end
                     WR_THROUGH: begin
                        latchLoad = 1'b1;
                        nxt_latch = data_ff & fetchMask(pWidth[p]);
                     end
                     WR_RBW: begin
                        latchLoad = 1'b1;
                        nxt_latch = fetchWord(memBits_ff, off, pWidth[p]);
                     end
                     default: begin
                        latchLoad = 1'b0;
                     end
                  endcase
               end
            end
         end

         always_ff @(posedge clk or posedge latchClr) begin
            if (latchClr) begin
               latch_ff <= DATA_RST;
            end else if (clkEn) begin
               if (pLatchRst[p] && pRstSync[p]) begin
                  latch_ff <= DATA_RST;
               end else if (latchLoad) begin
                  latch_ff <= nxt_latch;
               end
            end
         end

         // Optional output stage adds one cycle of latency for timing margin
         always_ff @(posedge clk or posedge latchClr) begin
            if (latchClr) begin
               out_ff <= DATA_RST;
            end else if (clkEn) begin
               if (pLatchRst[p] && pRstSync[p]) begin
                  out_ff <= DATA_RST;
               end else if (pOce[p]) begin
                  out_ff <= latch_ff;
               end
            end
         end

         assign pRead[p] = pOutReg[p] ? out_ff : latch_ff;
         assign wrReq[p]   = go_ff & we_ff;
         assign wrOffP[p]  = off;
         assign wrDataP[p] = data_ff;
      end
   endgenerate

   // Width 18 shifts the one out, so the subtraction wraps to all ones
   function automatic logic [DATA_W-1:0] fetchMask(input logic [2:0] code);
      fetchMask = (18'h00001 << widthOf(code)) - 18'h00001;
   endfunction

   assign readWordA = pRead[0];
   assign readWordB = pRead[1];

   // -------------------------------------------------
   // Array writes: preload, FIFO, then RAM ports
   // -------------------------------------------------
   always_ff @(posedge clk) begin
      if (clkEn) begin
         if (initLoad) begin
            for (int i = 0; i < INIT_DW; i++) begin
               memBits_ff[int'(initAddr) * INIT_DW + i] <= initWord[i];
            end
         end else if (wrGo) begin
            for (int i = 0; i < DATA_W; i++) begin
               if (i < int'(widthOf(widthA)) && (int'(wrOff) + i) < MEM_BITS) begin
                  memBits_ff[int'(wrOff) + i] <= writeWordInA[i];
               end
            end
         end else begin
            for (int q = 0; q < 2; q++) begin
               if (wrReq[q]) begin
                  for (int i = 0; i < DATA_W; i++) begin
                     if (i < int'(widthOf(pWidth[q])) && (int'(wrOffP[q]) + i) < MEM_BITS) begin
                        memBits_ff[int'(wrOffP[q]) + i] <= wrDataP[q][i];
                     end
                  end
               end
            end
         end
      end
   end

endmodule // bmf_block_memory

`default_nettype wire

// ---- verif/bmf_block_memory_monitor.sv ----
// Port-level checks for the block memory
`timescale 1ns/1ns
`default_nettype none
module bmf_block_memory_monitor
   import bmf_pkg::*;
(
   // Clock, reset, setup
   input wire logic              clk, sys_rst, clkEn, chipWideResetN, outRegEnA, latchRstSyncA,
   input wire logic [2:0]        memMode, widthA, writeSelMatch,
   input wire logic [1:0]        writeModeA, writePortSelect,
   // Port A and read data
   input wire logic              portClkEnA, portSelA, writeEnA, portALatchReset,
   input wire logic [DATA_W-1:0] writeWordInA, readWordA, readWordB,
   // FIFO
   input wire logic              writeClockGate, fifoWriteEn, fullChainInput, fetchEnable,
   input wire logic              fifoReset, readPointerRewindInput,
   input wire logic [PTR_W-1:0]  fullThreshold, nearlyFullThreshold, nearlyEmptyThreshold,
   input wire logic              fullFlag, nearlyFullFlag, emptyFlag, nearlyEmptyFlag
);
   // ----------
   // Qualifiers
   // ----------
   logic quiet, wrA, wrF;
   // No chip-wide, port A latch, FIFO or rewind reset may land while a check is open
   assign quiet = clkEn && chipWideResetN && !portALatchReset && !fifoReset && !readPointerRewindInput;
   assign wrA = quiet && portClkEnA && portSelA && writeEnA && memMode == MODE_SINGLE
      && !outRegEnA && widthA == WID_X9;
   assign wrF = quiet && memMode == MODE_FIFO && writeClockGate && fifoWriteEn && !fetchEnable
      && {fullChainInput, writePortSelect} == writeSelMatch;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------
   // Assertions
   // ----------
   a_chip_clears:
      assert property (!chipWideResetN |-> readWordA == DATA_RST && readWordB == DATA_RST && emptyFlag && !fullFlag)
      else $error("chip-wide reset left state behind");
   a_latch_rst_a:
      assert property (portALatchReset && !latchRstSyncA |-> readWordA == DATA_RST) else $error("latch A kept");
   a_fifo_rst:
      assert property (memMode == MODE_FIFO && fifoReset |-> emptyFlag && nearlyEmptyFlag && !fullFlag
         && !nearlyFullFlag) else $error("FIFO reset left flags");
   a_wr_through:
      assert property (wrA && writeModeA == WR_THROUGH ##1 quiet |=> readWordA == ($past(writeWordInA, 2) & 18'h001FF))
      else $error("written word not shown");
   a_normal_hold:
      assert property (wrA && writeModeA == WR_NORMAL ##1 quiet |=> $stable(readWordA)) else $error("output moved");
   a_upper_zero:
      assert property (widthA == WID_X9 |-> readWordA[17:9] == 9'h000) else $error("bits above width set");
   a_wr_not_empty:
      assert property (wrF ##1 quiet |=> !emptyFlag) else $error("empty after accepted write");
   a_full_nearly:
      assert property (fullFlag && nearlyFullThreshold <= fullThreshold && $stable(fullThreshold)
         && $stable(nearlyFullThreshold) |-> nearlyFullFlag) else $error("full without nearly full");
   a_empty_nearly:
      assert property (emptyFlag && $stable(nearlyEmptyThreshold) |-> nearlyEmptyFlag) else $error("empty alone");
endmodule // bmf_block_memory_monitor
bind bmf_block_memory bmf_block_memory_monitor i_mon (.*);
`default_nettype wire

// ---- verif/bmf_fabric_model.sv ----
// Fabric-side model sequencing the FIFO strobes around resets
`timescale 1ns/1ns
`default_nettype none
module bmf_fabric_model (
   // Clock and bench requests
   input  wire logic clk,
   input  wire logic rstReq,
   input  wire logic rwdReq,
   input  wire logic pushReq,
   input  wire logic pullReq,
   // Toward the block
   output logic      fifoWriteEn,
   output logic      fetchEnable,
   output logic      fifoReset,
   output logic      readPointerRewindInput
);
   // ----------
   // Reset sequencing
   // ----------
   logic [1:0] seq_ff;
   logic       quiet;
   always_ff @(posedge clk) begin
      seq_ff <= {seq_ff[0], rstReq | rwdReq};
   end
   // Strobes low a cycle before and two cycles after any async reset, so no edge races it
   assign quiet = rstReq | rwdReq | (|seq_ff);
   assign fifoReset = rstReq & seq_ff[0];
   assign readPointerRewindInput = rwdReq & seq_ff[0];
   assign fifoWriteEn = pushReq & ~quiet;
   assign fetchEnable = pullReq & ~quiet;
endmodule // bmf_fabric_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the block memory in RAM, ROM and FIFO modes
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import bmf_pkg::*;
   // ----------
   // Signals
   // ----------
   logic clk = 0, sys_rst = 1, clkEn = 1, chipWideResetN = 1, initLoad = 0, outRegEnA = 0, outRegEnB = 0;
   logic latchRstSyncA = 0, latchRstSyncB = 1, portClkEnA = 1, portClkEnB = 1, portSelA = 0, portSelB = 0;
   logic writeEnA = 0, writeEnB = 0, outputClockEnableA = 1, outputClockEnableB = 1, portALatchReset = 0;
   logic portBLatchReset = 0, writeClockGate = 1, readClockGate = 1, outputReadEnable = 1, fullChainInput = 0;
   logic emptyChainInput = 1, rstReq = 0, rwdReq = 0, pushReq = 0, pullReq = 0, reqA = 0, reqB = 0, reqF = 0;
   logic a1 = 0, a2 = 0, b1 = 0, b2 = 0;
   logic [2:0] memMode = MODE_SINGLE, widthA = WID_X9, widthB = WID_X9, writeSelMatch = 3'h5, readSelMatch = 3'h6;
   logic [1:0] writeModeA = WR_NORMAL, writeModeB = WR_NORMAL, writePortSelect = 2'h1, readPortSelect = 2'h2;
   logic [INIT_AW-1:0] initAddr = '0;
   logic [INIT_DW-1:0] initWord = '0;
   logic [ADDR_W-1:0]  addrA = '0, addrB = '0;
   logic [DATA_W-1:0]  writeWordInA = '0, writeWordInB = '0, readWordA, readWordB, lastA = '0;
   logic [PTR_W-1:0]   fullThreshold = 14'h0004, nearlyFullThreshold = 14'h0003, nearlyEmptyThreshold = 14'h0001;
   logic fifoWriteEn, fetchEnable, fifoReset, readPointerRewindInput;
   logic fullFlag, nearlyFullFlag, emptyFlag, nearlyEmptyFlag;
   logic [DATA_W-1:0] qA [$], qB [$];
   logic [8:0] fdat [$], mdl [1024];
   logic [31:0] seed = 32'h0000000B;
   int bad_count = 0, compares = 0, ri = 0;
   bmf_block_memory i_dut (.*);
   bmf_fabric_model i_fab (.*);
   always #4 clk = ~clk;
   // ----------
   // Helpers
   // ----------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic stop_test();
      if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [DATA_W-1:0] e, s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // Flags lag an operation by one edge, so settle two edges first
   task automatic cf(input logic [3:0] e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp("flags", {14'h0000, e}, {14'h0000, fullFlag, nearlyFullFlag, emptyFlag, nearlyEmptyFlag});
   endtask
   task automatic ram(input bit p, we, c, input int a, input logic [DATA_W-1:0] d, e);
      @(posedge clk);
      if (p) begin
         {portSelB, writeEnB, reqB, addrB, writeWordInB} <= {1'b1, we, c, 13'(a), d};
         if (c) qB.push_back(e);
      end else begin
         {portSelA, writeEnA, reqA, addrA, writeWordInA} <= {1'b1, we, c, 13'(a), d};
         if (c) qA.push_back(e);
         if (c) lastA = e;
      end
      @(posedge clk);
      {portSelA, portSelB, writeEnA, writeEnB, reqA, reqB} <= '0;
   endtask
   task automatic fio(input bit w, input int n);
      logic [8:0] v;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         v = 9'(rnd());
         {pushReq, pullReq, writeWordInA} <= {w, !w, 9'h000, v};
         if (w && fdat.size() - ri < 4) fdat.push_back(v);
         reqF <= !w && ri < fdat.size();
         if (!w && ri < fdat.size()) qB.push_back({9'h000, fdat[ri++]});
      end
      @(posedge clk);
      {pushReq, pullReq, reqF} <= '0;
   endtask
   // RAM data shows two edges after the request, FIFO data one edge after
   always @(negedge clk) begin
      if (a2) cmp("readWordA", qA.pop_front(), readWordA);
      if (b2) cmp("readWordB", qB.pop_front(), readWordB);
      a2 = a1;
      a1 = reqA;
      b2 = b1 | reqF;
      b1 = reqB;
   end
   initial begin
      repeat (4000) @(posedge clk);
      bad_count++;
      stop_test();
   end
   // ----------
   // Sequence
   // ----------
   initial begin
      logic [8:0] d;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      cf(4'h3);
      for (int m = 0; m < 3; m++) begin
         writeModeA <= m[1:0];
         for (int i = 0; i < 4; i++) begin
            d = 9'(rnd());
            ram(0, 1, 1, i, {9'h000, d}, m == 1 ? {9'h000, d} : m == 2 ? {9'h000, mdl[i]} : lastA);
            mdl[i] = d;
         end
         for (int i = 0; i < 4; i++) ram(0, 0, 1, i, '0, {9'h000, mdl[i]});
      end
      {memMode, widthB} <= {MODE_PSEUDO, WID_X18};
      ram(1, 0, 1, 0, '0, {mdl[1], mdl[0]});
      @(posedge clk) {memMode, widthB} <= {MODE_DUAL, WID_X9};
      ram(1, 1, 0, 5, 18'h00123, '0);
      memMode <= MODE_SINGLE;
      ram(0, 0, 1, 5, '0, 18'h00123);
      ram(0, 0, 1, 2, '0, {9'h000, mdl[2]});
      repeat (3) @(posedge clk);
      {portALatchReset, portBLatchReset} <= 2'h3;
      @(posedge clk) {portALatchReset, portBLatchReset} <= 2'h0;
      @(negedge clk) cmp("readWordA", '0, readWordA);
      cmp("readWordB", '0, readWordB);
      ram(0, 0, 1, 3, '0, {9'h000, mdl[3]});
      repeat (2) @(posedge clk);
      outRegEnA <= 1'b1;
      ram(0, 0, 0, 1, '0, '0);
      @(posedge clk);
      @(negedge clk) cmp("readWordA", {9'h000, mdl[3]}, readWordA);
      @(negedge clk) cmp("readWordA", {9'h000, mdl[1]}, readWordA);
      @(posedge clk) {outRegEnA, clkEn} <= 2'h0;
      @(posedge clk) chipWideResetN <= 1'b0;
      @(posedge clk) chipWideResetN <= 1'b1;
      @(posedge clk) clkEn <= 1'b1;
      @(negedge clk) cmp("readWordA", '0, readWordA);
      lastA = '0;
      @(posedge clk) {initLoad, initAddr, initWord} <= {1'b1, 10'h014, 9'h1A5};
      @(posedge clk) {initLoad, memMode, widthB} <= {1'b0, MODE_ROM, WID_X9};
      ram(1, 1, 0, 20, 18'h0005A, '0);
      ram(1, 0, 1, 20, '0, 18'h001A5);
      @(posedge clk) memMode <= MODE_FIFO;
      fio(1, 1);
      cf(4'h3);
      fdat.delete();
      fullChainInput <= 1'b1;
      fio(1, 3);
      cf(4'h4);
      fio(1, 2);
      cf(4'hC);
      fio(0, 3);
      cf(4'h1);
      fio(0, 2);
      cf(4'h3);
      @(posedge clk) rwdReq <= 1'b1;
      repeat (2) @(posedge clk);
      rwdReq <= 1'b0;
      ri = 0;
      cf(4'hC);
      fio(0, 4);
      fio(1, 2);
      @(posedge clk) rstReq <= 1'b1;
      repeat (2) @(posedge clk);
      rstReq <= 1'b0;
      cf(4'h3);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
